// file: hw/oper_state_pkg.sv
// Constants and types for the remote/local operating state machine.
// Assumes one 25 MHz clock and an active-low asynchronous reset.
//
// Summary of operation
// - Local state accepts front panel and lets every remote command run.
// - Local with lockout acts as local; REN asserted plus listener addressing goes to remote lockout.
// - Bus lockout message with REN asserted, or serial lockout command, moves local to local with lockout.
// - REN asserted plus listener addressing moves local to remote.
// - In remote only the power switch and local selection pass.
// - Remote returns to local on panel local selection or GTL.
// - Remote with lockout entered only from remote or local with lockout.
// - Remote with lockout hides local selection; operator cannot request local.
// - GTL in remote with lockout moves to local with lockout.
// - REN released in remote with lockout returns to plain local.

package oper_state_pkg;

  // ----------------------------------------------------------------
  // Front panel and pin layout
  // ----------------------------------------------------------------
  localparam int unsigned PANEL_W    = 8;
  localparam int unsigned POWER_BIT  = 0;
  localparam int unsigned LOCAL_BIT  = 1;
  localparam int unsigned SYNC_W     = PANEL_W + 1;
  localparam int unsigned REN_BIT    = PANEL_W;

  // Keys that still pass while remote, and while remote with lockout
  localparam logic [PANEL_W-1:0] REMOTE_KEEP = 8'h03;
  localparam logic [PANEL_W-1:0] RLOCK_KEEP  = 8'h01;
  localparam logic [PANEL_W-1:0] ALL_KEYS    = 8'hFF;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [SYNC_W-1:0]  SYNC_RST  = 9'h000;
  localparam logic [PANEL_W-1:0] PANEL_RST = 8'h00;

  // ----------------------------------------------------------------
  // Operating states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_LOCAL,
    ST_LOCAL_LOCK,
    ST_REMOTE,
    ST_REMOTE_LOCK
  } op_state_t;

endpackage : oper_state_pkg

// file: hw/pin_sync_if.sv
// Carrier between the state machine and its pin synchroniser.
// Assumes raw pins are asynchronous to the block clock.
`timescale 1ns/1ps

interface pin_sync_if;
  logic [oper_state_pkg::SYNC_W-1:0] raw;
  logic [oper_state_pkg::SYNC_W-1:0] clean;

  modport sync_side (input raw, output clean);
  modport user_side (output raw, input clean);
endinterface : pin_sync_if

// file: hw/pin_sync.sv
// Two-flop synchroniser for the REN pin and front panel inputs.
// Assumes single clock domain on the output side.
`timescale 1ns/1ps

module pin_sync (
  input  wire logic          clock,
  input  wire logic          arst_n,
  pin_sync_if.sync_side      pins
);

  // ----------------------------------------------------------------
  // Per-bit double flop
  // ----------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < oper_state_pkg::SYNC_W; b++) begin : g_bit
      logic meta_r;
      logic hold_r;

      // First stage feeds only the second stage
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          meta_r <= oper_state_pkg::SYNC_RST[b];
          hold_r <= oper_state_pkg::SYNC_RST[b];
        end else begin
          meta_r <= pins.raw[b];
          hold_r <= meta_r;
        end
      end

      assign pins.clean[b] = hold_r;
    end
  endgenerate

endmodule : pin_sync

// file: hw/oper_state_fsm.sv
// Remote/local/lockout operating state machine with front panel gating.
// Assumes bus message strobes are one-cycle pulses on this clock; REN and
// panel keys are raw pins.
`timescale 1ns/1ps

module oper_state_fsm (
  input  wire logic                                clock,
  input  wire logic                                arst_n,
  input  wire logic                                ren_pin,
  input  wire logic [oper_state_pkg::PANEL_W-1:0]  panel_pin,
  input  wire logic                                listen_addr,
  input  wire logic                                gtl_msg,
  input  wire logic                                llo_msg,
  input  wire logic                                serial_lockout,
  input  wire logic                                remote_cmd_valid,
  output logic [oper_state_pkg::PANEL_W-1:0]       panel_keys,
  output logic                                     remote_cmd_exec,
  output logic                                     remote_mode,
  output logic                                     lockout_mode,
  output logic                                     local_ctl_shown,
  output logic [1:0]                               state_code
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  pin_sync_if sync_bus ();

  assign sync_bus.raw = {ren_pin, panel_pin};

  pin_sync u_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .pins   (sync_bus)
  );

  logic                               ren_s;
  logic [oper_state_pkg::PANEL_W-1:0] panel_s;

  assign ren_s   = sync_bus.clean[oper_state_pkg::REN_BIT];
  assign panel_s = sync_bus.clean[oper_state_pkg::PANEL_W-1:0];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  oper_state_pkg::op_state_t          state_r;
  oper_state_pkg::op_state_t          state_nxt;
  logic                               local_prev_r;
  logic [oper_state_pkg::PANEL_W-1:0] panel_keys_r;
  logic [oper_state_pkg::PANEL_W-1:0] panel_keys_nxt;
  logic                               cmd_exec_r;
  logic                               remote_r;
  logic                               lockout_r;
  logic                               shown_r;

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  logic local_rise;
  logic lock_req;
  logic remote_req;
  logic back_local;

  // Panel local selection, rising edge of synced key
  assign local_rise = panel_s[oper_state_pkg::LOCAL_BIT] & ~local_prev_r;
  // Bus lockout needs REN; serial lockout does not
  assign lock_req   = (llo_msg & ren_s) | serial_lockout;
  // Addressed as listener with REN asserted
  assign remote_req = ren_s & listen_addr;
  // Return from remote by GTL or panel local selection
  assign back_local = gtl_msg | local_rise;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      oper_state_pkg::ST_LOCAL: begin
        if (lock_req) begin
          state_nxt = oper_state_pkg::ST_LOCAL_LOCK;
        end else if (remote_req) begin
          state_nxt = oper_state_pkg::ST_REMOTE;
        end
      end
      oper_state_pkg::ST_LOCAL_LOCK: begin
        if (!ren_s) begin
          state_nxt = oper_state_pkg::ST_LOCAL;
        end else if (remote_req) begin
          state_nxt = oper_state_pkg::ST_REMOTE_LOCK;
        end
      end
      oper_state_pkg::ST_REMOTE: begin
        if (!ren_s || back_local) begin
          state_nxt = oper_state_pkg::ST_LOCAL;
        end else if (lock_req) begin
          state_nxt = oper_state_pkg::ST_REMOTE_LOCK;
        end
      end
      oper_state_pkg::ST_REMOTE_LOCK: begin
        if (!ren_s) begin
          state_nxt = oper_state_pkg::ST_LOCAL;
        end else if (gtl_msg) begin
          state_nxt = oper_state_pkg::ST_LOCAL_LOCK;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Output decode from the next state
  // ----------------------------------------------------------------
  logic                               nxt_remote;
  logic                               nxt_lockout;
  logic [oper_state_pkg::PANEL_W-1:0] key_mask;

  assign nxt_remote  = (state_nxt == oper_state_pkg::ST_REMOTE) ||
                       (state_nxt == oper_state_pkg::ST_REMOTE_LOCK);
  assign nxt_lockout = (state_nxt == oper_state_pkg::ST_LOCAL_LOCK) ||
                       (state_nxt == oper_state_pkg::ST_REMOTE_LOCK);

  // Panel keys gated by state
  assign key_mask =
    (state_nxt == oper_state_pkg::ST_REMOTE_LOCK) ?
      oper_state_pkg::RLOCK_KEEP :
    (state_nxt == oper_state_pkg::ST_REMOTE) ?
      oper_state_pkg::REMOTE_KEEP :
      oper_state_pkg::ALL_KEYS;

  assign panel_keys_nxt = panel_s & key_mask;

  // ----------------------------------------------------------------
  // State and output flops
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= oper_state_pkg::ST_LOCAL;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Edge history for local selection
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      local_prev_r <= 1'b0;
    end else begin
      local_prev_r <= panel_s[oper_state_pkg::LOCAL_BIT];
    end
  end

  // Registered outputs
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      panel_keys_r <= oper_state_pkg::PANEL_RST;
      cmd_exec_r   <= 1'b0;
      remote_r     <= 1'b0;
      lockout_r    <= 1'b0;
      shown_r      <= 1'b0;
    end else begin
      panel_keys_r <= panel_keys_nxt;
      cmd_exec_r   <= remote_cmd_valid;
      remote_r     <= nxt_remote;
      lockout_r    <= nxt_lockout;
      shown_r      <= (state_nxt == oper_state_pkg::ST_REMOTE);
    end
  end

  assign panel_keys      = panel_keys_r;
  assign remote_cmd_exec = cmd_exec_r;
  assign remote_mode     = remote_r;
  assign lockout_mode    = lockout_r;
  assign local_ctl_shown = shown_r;
  assign state_code      = state_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_local_keys_pass: assert property (
    state_r == oper_state_pkg::ST_LOCAL |-> panel_keys_r == $past(panel_s))
    else $error("local state did not pass panel keys");

  a_cmd_always_runs: assert property (
    remote_cmd_exec == $past(remote_cmd_valid))
    else $error("remote command not executed");

  a_llock_to_rlock: assert property (
    state_r == oper_state_pkg::ST_LOCAL_LOCK && remote_req
    |=> state_r == oper_state_pkg::ST_REMOTE_LOCK && lockout_mode)
    else $error("lockout did not carry into remote");

  a_lockout_entry: assert property (
    state_r == oper_state_pkg::ST_LOCAL && lock_req
    |=> state_r == oper_state_pkg::ST_LOCAL_LOCK && !remote_mode)
    else $error("lockout request not honoured");

  a_local_to_remote: assert property (
    state_r == oper_state_pkg::ST_LOCAL && !lock_req && remote_req
    |=> state_r == oper_state_pkg::ST_REMOTE && local_ctl_shown)
    else $error("listener addressing did not enter remote");

  a_remote_key_mask: assert property (
    state_r == oper_state_pkg::ST_REMOTE
    |-> panel_keys_r == ($past(panel_s) & oper_state_pkg::REMOTE_KEEP))
    else $error("remote state let blocked keys through");

  a_remote_go_local: assert property (
    state_r == oper_state_pkg::ST_REMOTE && back_local
    |=> state_r == oper_state_pkg::ST_LOCAL && !remote_mode)
    else $error("remote did not return to local");

  a_rlock_entry_src: assert property (
    state_r == oper_state_pkg::ST_REMOTE_LOCK
    |-> $past(state_r) != oper_state_pkg::ST_LOCAL)
    else $error("remote lockout entered from plain local");

  a_rlock_hides_local: assert property (
    state_r == oper_state_pkg::ST_REMOTE_LOCK
    |-> !local_ctl_shown && !panel_keys[oper_state_pkg::LOCAL_BIT])
    else $error("local selection visible under lockout");

  a_rlock_gtl: assert property (
    state_r == oper_state_pkg::ST_REMOTE_LOCK && ren_s && gtl_msg
    |=> state_r == oper_state_pkg::ST_LOCAL_LOCK)
    else $error("GTL under lockout did not reach local lockout");

  a_ren_drop_local: assert property (
    state_r == oper_state_pkg::ST_REMOTE_LOCK && !ren_s
    |=> state_r == oper_state_pkg::ST_LOCAL && !lockout_mode)
    else $error("REN release did not return to local");

  a_flags_match: assert property (
    remote_mode == state_r[1] &&
    lockout_mode == (state_r == oper_state_pkg::ST_LOCAL_LOCK ||
                     state_r == oper_state_pkg::ST_REMOTE_LOCK))
    else $error("status flags disagree with state");

  // Panel gating and local selection in the lockout states
  a_llock_keys_pass: assert property (
    state_r == oper_state_pkg::ST_LOCAL_LOCK
    |-> panel_keys_r == $past(panel_s))
    else $error("local lockout did not pass panel keys");

  a_rlock_key_mask: assert property (
    state_r == oper_state_pkg::ST_REMOTE_LOCK
    |-> panel_keys_r == ($past(panel_s) & oper_state_pkg::RLOCK_KEEP))
    else $error("remote lockout let blocked keys through");

  a_rlock_local_key: assert property (
    state_r == oper_state_pkg::ST_REMOTE_LOCK && ren_s && !gtl_msg
    |=> state_r == oper_state_pkg::ST_REMOTE_LOCK)
    else $error("remote lockout left without GTL or REN release");

  // Transitions that must happen and ones that must not
  a_remote_lock_src: assert property (
    state_r == oper_state_pkg::ST_REMOTE && ren_s && !back_local && lock_req
    |=> state_r == oper_state_pkg::ST_REMOTE_LOCK)
    else $error("lockout in remote did not reach remote lockout");

  a_local_never_rlock: assert property (
    state_r == oper_state_pkg::ST_LOCAL
    |=> state_r != oper_state_pkg::ST_REMOTE_LOCK)
    else $error("plain local jumped to remote lockout");

  a_remote_holds: assert property (
    state_r == oper_state_pkg::ST_REMOTE && ren_s && !back_local && !lock_req
    |=> state_r == oper_state_pkg::ST_REMOTE)
    else $error("remote left on an ignored input");

  a_local_holds: assert property (
    state_r == oper_state_pkg::ST_LOCAL && !lock_req && !remote_req
    |=> state_r == oper_state_pkg::ST_LOCAL)
    else $error("local left without lockout or addressing");

  a_shown_only_remote: assert property (
    local_ctl_shown |-> state_r == oper_state_pkg::ST_REMOTE)
    else $error("local selection shown outside plain remote");

  // ----------------------------------------------------------------
  // Cover properties
  // ----------------------------------------------------------------
  // Main scenarios reached by the bench
  c_local_remote: cover property (
    state_r == oper_state_pkg::ST_LOCAL ##1
    state_r == oper_state_pkg::ST_REMOTE);

  c_full_lockout: cover property (
    state_r == oper_state_pkg::ST_LOCAL_LOCK ##1
    state_r == oper_state_pkg::ST_REMOTE_LOCK);

  c_rlock_gtl: cover property (
    state_r == oper_state_pkg::ST_REMOTE_LOCK ##1
    state_r == oper_state_pkg::ST_LOCAL_LOCK);

  c_panel_local: cover property (
    state_r == oper_state_pkg::ST_REMOTE && local_rise && !gtl_msg);

  c_serial_lock: cover property (
    state_r == oper_state_pkg::ST_LOCAL && serial_lockout ##1
    state_r == oper_state_pkg::ST_LOCAL_LOCK);

endmodule : oper_state_fsm

// file: verif/remote_ctl_model.sv
// Behavioural remote controller: REN level and bus message strobes.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps

module remote_ctl_model (
  input  wire logic clock,
  output logic      ren_pin,
  output logic      listen_addr,
  output logic      gtl_msg,
  output logic      llo_msg,
  output logic      serial_lockout,
  output logic      remote_cmd_valid
);
  // Bus idle at start: REN released, no messages
  initial begin
    ren_pin          = 1'b0;
    listen_addr      = 1'b0;
    gtl_msg          = 1'b0;
    llo_msg          = 1'b0;
    serial_lockout   = 1'b0;
    remote_cmd_valid = 1'b0;
  end

  // REN level change, launched just after an edge
  task automatic set_ren(input logic v);
    @(posedge clock);
    ren_pin <= v;
  endtask : set_ren

  // One-cycle strobe: 0 command, 1 listen, 2 GTL, 3 LLO, 4 serial lock
  task automatic pulse(input logic [2:0] k);
    @(posedge clock);
    remote_cmd_valid <= (k == 3'h0);
    listen_addr      <= (k == 3'h1);
    gtl_msg          <= (k == 3'h2);
    llo_msg          <= (k == 3'h3);
    serial_lockout   <= (k == 3'h4);
    @(posedge clock);
    {remote_cmd_valid, listen_addr, gtl_msg, llo_msg, serial_lockout} <= 5'h00;
  endtask : pulse
endmodule : remote_ctl_model

// file: verif/remote_local_lockout_fsm_tb_top.sv
// Self-checking bench for the operating state machine.
// Assumes the remote controller model drives all bus strobes.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end

module remote_local_lockout_fsm_tb_top;
  logic       clock = 1'b0;
  logic       arst_n = 1'b0;
  logic [7:0] panel_pin = 8'hFD;
  logic       ren_pin, listen_addr, gtl_msg, llo_msg;
  logic       serial_lockout, remote_cmd_valid;
  logic [7:0] panel_keys;
  logic       remote_cmd_exec, remote_mode, lockout_mode, local_ctl_shown;
  logic [1:0] state_code;
  int         err_total = 0;
  int         n_checks = 0;
  // Rows: operation code then expected state; 5 REN on, 6 REN off, 7 key
  logic [4:0] rows [23] = '{
    5'h00, 5'h04, 5'h14, 5'h06, 5'h08, // Refused listen, remote, GTL
    5'h08, 5'h06, 5'h1C, 5'h0D, 5'h07,
    5'h1F, 5'h09, 5'h09, 5'h18, 5'h14,
    5'h11, 5'h07, 5'h18, 5'h14, 5'h06,
    5'h0F, 5'h18, 5'h14};
  int         i;

  // ----------------------------------------------------------------
  // Clock, parts under test
  // ----------------------------------------------------------------
  initial begin
    forever #20 clock = ~clock;
  end

  remote_ctl_model remote_ctl_model_i (
    .clock            (clock),
    .ren_pin          (ren_pin),
    .listen_addr      (listen_addr),
    .gtl_msg          (gtl_msg),
    .llo_msg          (llo_msg),
    .serial_lockout   (serial_lockout),
    .remote_cmd_valid (remote_cmd_valid)
  );

  oper_state_fsm oper_state_fsm_i (
    .clock            (clock),
    .arst_n           (arst_n),
    .ren_pin          (ren_pin),
    .panel_pin        (panel_pin),
    .listen_addr      (listen_addr),
    .gtl_msg          (gtl_msg),
    .llo_msg          (llo_msg),
    .serial_lockout   (serial_lockout),
    .remote_cmd_valid (remote_cmd_valid),
    .panel_keys       (panel_keys),
    .remote_cmd_exec  (remote_cmd_exec),
    .remote_mode      (remote_mode),
    .lockout_mode     (lockout_mode),
    .local_ctl_shown  (local_ctl_shown),
    .state_code       (state_code)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Compare all state outputs against one expected state
  task automatic chk_state(input logic [1:0] s);
    logic [7:0] m;
    m = (s == 2'h2) ? 8'h03 : (s == 2'h3) ? 8'h01 : 8'hFF;
    `CHK(state_code, s)
    `CHK(remote_mode, s[1])
    `CHK(lockout_mode, (s == 2'h1) || (s == 2'h3))
    `CHK(local_ctl_shown, s == 2'h2)
    `CHK(panel_keys, arst_n ? (panel_pin & m) : 8'h00)
  endtask : chk_state

  // Apply one operation and let synchroniser and state settle
  task automatic do_op(input logic [2:0] op);
    if (op < 3'h5) remote_ctl_model_i.pulse(op);
    else if (op < 3'h7) remote_ctl_model_i.set_ren(op == 3'h5);
    else begin
      @(posedge clock);
      panel_pin <= 8'hFF;
      repeat (4) @(posedge clock);
      panel_pin <= 8'hFD;
    end
    repeat (5) @(posedge clock);
    #1;
  endtask : do_op

  // Command strobe runs one cycle later, for one cycle
  task automatic cmd_check;
    remote_ctl_model_i.pulse(3'h0);
    #1;
    `CHK(remote_cmd_exec, 1'b1)
    @(posedge clock);
    #1;
    `CHK(remote_cmd_exec, 1'b0)
  endtask : cmd_check

  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    @(posedge clock);
    #1;
    chk_state(2'h0);
    @(posedge clock);
    arst_n <= 1'b1;
    repeat (2) @(posedge clock);
    for (i = 0; i < 23; i++) begin
      do_op(rows[i][4:2]);
      chk_state(rows[i][1:0]);
    end
    cmd_check();
    do_op(3'h3);
    chk_state(2'h1);
    cmd_check();
    do_op(3'h1);
    chk_state(2'h3);
    @(posedge clock);
    arst_n <= 1'b0;
    #1;
    chk_state(2'h0);
    @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk_state(2'h0);
    end_sim();
  end

  initial begin
    repeat (3000) @(posedge clock);
    err_total++;
    end_sim();
  end
endmodule : remote_local_lockout_fsm_tb_top
